// >>> verilog/spf_map.svh
// register offsets, write masks, reset values and limits for the port policy block
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH
`define SPF_ADR_CTRL 8'h00
`define SPF_ADR_MAXLEN 8'h04
`define SPF_ADR_HASH 8'h08
`define SPF_ADR_STATUS 8'h0c
`define SPF_ADR_STATS 8'h10
`define SPF_CTRL_RST 32'h0002007c
`define SPF_CTRL_MASK 32'h0003ffff
`define SPF_MAXLEN_RST 14'h05ee
`define SPF_MAXLEN_MIN 14'h05ee
`define SPF_MAXLEN_MAX 14'h2800
`define SPF_HASH_RST 32'h0000001d
`define SPF_HASH_MASK 32'h000000ff
`define SPF_TYPE_MAX 16'h05ff
`define SPF_HDR_FCS 14'h0012
`define SPF_COL_LIMIT 5'h10
`define SPF_ETH_IPV4 16'h0800
`define SPF_PROTO_TCP 8'h06
`define SPF_PROTO_UDP 8'h11
`endif

// >>> verilog/spf_pkg.sv
// types shared by the port policy block
package spf_pkg;
  // speed selection
  typedef enum logic [1:0] {
    SPF_SPD_AUTO = 2'h0,
    SPF_SPD_FIXED = 2'h1,
    SPF_SPD_100FX = 2'h2,
    SPF_SPD_FIXED2 = 2'h3
  } spf_speed_type;
  // receive parser states, gray along idle -> recv -> done
  typedef enum logic [1:0] {
    SPF_RX_IDLE = 2'h0,
    SPF_RX_RECV = 2'h1,
    SPF_RX_DONE = 2'h3
  } spf_rx_state_type;
  // control register layout
  typedef struct packed {
    logic [13:0] rsvd;
    logic len_check;
    logic col_restart;
    logic [7:0] pfc_prio;
    logic pfc_en;
    logic pause_tx;
    logic pause_rx;
    logic [2:0] adv_speed;
    spf_speed_type speed;
  } spf_ctrl_type;
  // trunk hash register layout
  typedef struct packed {
    logic [23:0] rsvd;
    logic [3:0] members;
    logic use_l4;
    logic use_ip;
    logic use_dst;
    logic use_src;
  } spf_hash_type;
  // frame verdict
  typedef struct packed {
    logic pass;
    logic drop_len;
    logic drop_size;
    logic [2:0] member;
  } spf_verdict_type;
endpackage

// >>> verilog/spf_top.sv
// per-port frame policy, pause negotiation, collision policy and trunk hash
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "spf_map.svh"
module spf_top
  import spf_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // auto-negotiation
  input wire logic an_done_i,
  input wire logic an_partner_pause_i,
  input wire logic an_partner_asym_i,
  output logic [2:0] an_adv_speed_o,
  output logic [1:0] an_adv_pause_o,
  // flow control
  input wire logic [7:0] pfc_congest_i,
  output logic [7:0] pfc_pause_o,
  output logic pause_obey_o,
  output logic pause_gen_o,
  // transmit collisions
  input wire logic tx_start_i,
  input wire logic tx_collision_i,
  output logic tx_abort_o,
  output logic tx_backoff_restart_o,
  // receive byte stream
  input wire logic rx_valid_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  input wire logic [7:0] rx_data_i,
  // frame verdict
  output logic rx_done_o,
  output logic rx_pass_o,
  output logic rx_drop_o,
  output logic [2:0] egress_member_o
);
  spf_ctrl_type ctrl_reg; // control register
  spf_hash_type hash_reg; // trunk hash register
  logic [13:0] maxlen_reg; // frame length limit
  logic [15:0] size_drops_reg; // oversize drop count
  logic [15:0] col_drops_reg; // excessive collision discard count
  logic ack_reg; // bus acknowledge
  logic [31:0] rdat_reg; // read data
  logic [31:0] wmask; // byte lane write mask
  logic wr_ctrl, wr_maxlen, wr_hash; // write strobes at ack edge
  logic [31:0] ctrl_next, hash_next, len_next; // merged write values
  logic neg_rx_reg, neg_tx_reg; // last negotiation outcome
  logic cur_rx, cur_tx; // active pause state
  logic [4:0] col_cnt_reg; // collisions of current frame
  logic abort_reg, restart_reg; // collision pulses
  spf_rx_state_type rx_state_reg; // receive parser state
  logic [13:0] byte_cnt_reg; // bytes received incl fcs
  logic [15:0] typelen_reg; // type/length field
  logic [7:0] proto_reg; // ip protocol byte
  logic [7:0] acc_src_reg, acc_dst_reg, acc_ip_reg, acc_l4_reg; // fold accumulators
  logic [13:0] pos; // position of current byte
  logic [13:0] total; // frame length at end of frame
  logic [13:0] payload; // payload length at end of frame
  logic is_ip, is_l4; // header kinds
  logic oversize, len_bad; // drop causes
  logic [7:0] hash_val; // folded hash
  logic [3:0] mem_cnt; // active member count, at least one
  logic [7:0] hash_mod; // hash modulo members
  spf_verdict_type verdict_reg; // registered verdict
  // classic wishbone request
  wire bus_req = wb_cyc_i & wb_stb_i;
  // byte lane mask from sel
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // write takes effect on the edge where ack is high
  assign wr_ctrl = bus_req & wb_we_i & ack_reg & (wb_adr_i == `SPF_ADR_CTRL);
  assign wr_maxlen = bus_req & wb_we_i & ack_reg & (wb_adr_i == `SPF_ADR_MAXLEN);
  assign wr_hash = bus_req & wb_we_i & ack_reg & (wb_adr_i == `SPF_ADR_HASH);
  assign ctrl_next = (((ctrl_reg & ~wmask) | (wb_dat_i & wmask)) & `SPF_CTRL_MASK);
  assign hash_next = (((hash_reg & ~wmask) | (wb_dat_i & wmask)) & `SPF_HASH_MASK);
  assign len_next = ({18'h0, maxlen_reg} & ~wmask) | (wb_dat_i & wmask);
  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end
  assign wb_ack_o = ack_reg;
  // read data captured with ack, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0;
    end else if (bus_req & ~ack_reg) begin
      case (wb_adr_i)
        `SPF_ADR_CTRL: rdat_reg <= ctrl_reg;
        `SPF_ADR_MAXLEN: rdat_reg <= {18'h0, maxlen_reg};
        `SPF_ADR_HASH: rdat_reg <= hash_reg;
        `SPF_ADR_STATUS: rdat_reg <= {24'h0, col_cnt_reg, ctrl_reg.pfc_en, cur_tx, cur_rx};
        `SPF_ADR_STATS: rdat_reg <= {col_drops_reg, size_drops_reg};
        default: rdat_reg <= 32'h0;
      endcase
    end
  end
  assign wb_dat_o = rdat_reg;
  // control and hash registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `SPF_CTRL_RST;
      hash_reg <= `SPF_HASH_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_next;
      end
      if (wr_hash) begin
        hash_reg <= hash_next;
      end
    end
  end
  // length limit, clamped into its legal range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      maxlen_reg <= `SPF_MAXLEN_RST;
    end else if (wr_maxlen) begin
      if (len_next[31:14] != 18'h0 || len_next[13:0] > `SPF_MAXLEN_MAX) begin
        maxlen_reg <= `SPF_MAXLEN_MAX;
      end else if (len_next[13:0] < `SPF_MAXLEN_MIN) begin
        maxlen_reg <= `SPF_MAXLEN_MIN;
      end else begin
        maxlen_reg <= len_next[13:0];
      end
    end
  end
  // advertisement: masked speeds in auto mode, nothing in the fixed and fibre modes
  always_comb begin
    if (ctrl_reg.speed == SPF_SPD_AUTO) begin
      an_adv_speed_o = ctrl_reg.adv_speed;
      an_adv_pause_o = {ctrl_reg.pause_tx, ctrl_reg.pause_rx};
    end else begin
      an_adv_speed_o = 3'h0;
      an_adv_pause_o = 2'h0;
    end
  end
  // latch the outcome of each completed negotiation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      neg_rx_reg <= 1'b0;
      neg_tx_reg <= 1'b0;
    end else if (an_done_i) begin
      neg_rx_reg <= ctrl_reg.pause_rx & an_partner_pause_i;
      neg_tx_reg <= ctrl_reg.pause_tx & (an_partner_pause_i | an_partner_asym_i);
    end
  end
  // active pause state per speed mode
  always_comb begin
    case (ctrl_reg.speed)
      SPF_SPD_AUTO: begin
        cur_rx = neg_rx_reg;
        cur_tx = neg_tx_reg;
      end
      SPF_SPD_100FX: begin
        cur_rx = 1'b0;
        cur_tx = 1'b0;
      end
      default: begin
        cur_rx = ctrl_reg.pause_rx;
        cur_tx = ctrl_reg.pause_tx;
      end
    endcase
  end
  // pfc excludes ordinary pause; pfc never depends on negotiation
  assign pause_obey_o = cur_rx & ~ctrl_reg.pfc_en;
  assign pause_gen_o = cur_tx & ~ctrl_reg.pfc_en;
  assign pfc_pause_o = ctrl_reg.pfc_en ? (pfc_congest_i & ctrl_reg.pfc_prio) : 8'h0;
  // collision counting and excessive collision policy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_cnt_reg <= 5'h0;
      abort_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      abort_reg <= 1'b0;
      restart_reg <= 1'b0;
      if (tx_start_i) begin
        col_cnt_reg <= 5'h0;
      end else if (tx_collision_i) begin
        if (col_cnt_reg + 5'h1 == `SPF_COL_LIMIT) begin
          col_cnt_reg <= 5'h0;
          abort_reg <= ~ctrl_reg.col_restart;
          restart_reg <= ctrl_reg.col_restart;
        end else begin
          col_cnt_reg <= col_cnt_reg + 5'h1;
        end
      end
    end
  end
  assign tx_abort_o = abort_reg;
  assign tx_backoff_restart_o = restart_reg;
  // receive parser state; a start of frame restarts it from any state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= SPF_RX_IDLE;
    end else if (rx_valid_i & rx_sof_i) begin
      rx_state_reg <= rx_eof_i ? SPF_RX_DONE : SPF_RX_RECV;
    end else begin
      case (rx_state_reg)
        SPF_RX_RECV: begin
          if (rx_valid_i & rx_eof_i) begin
            rx_state_reg <= SPF_RX_DONE;
          end
        end
        SPF_RX_DONE: rx_state_reg <= SPF_RX_IDLE;
        default: rx_state_reg <= SPF_RX_IDLE;
      endcase
    end
  end
  // byte position, restarted by start of frame
  assign pos = rx_sof_i ? 14'h0 : byte_cnt_reg;
  wire rx_take = rx_valid_i & (rx_sof_i | (rx_state_reg == SPF_RX_RECV));
  assign is_ip = (typelen_reg == `SPF_ETH_IPV4);
  assign is_l4 = is_ip & ((proto_reg == `SPF_PROTO_TCP) | (proto_reg == `SPF_PROTO_UDP));
  // header capture and xor folding per contributor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_cnt_reg <= 14'h0;
      typelen_reg <= 16'h0;
      proto_reg <= 8'h0;
      acc_src_reg <= 8'h0;
      acc_dst_reg <= 8'h0;
      acc_ip_reg <= 8'h0;
      acc_l4_reg <= 8'h0;
    end else if (rx_take) begin
      if (byte_cnt_reg != 14'h3fff || rx_sof_i) begin
        byte_cnt_reg <= pos + 14'h1;
      end
      if (rx_sof_i) begin
        acc_dst_reg <= rx_data_i;
        acc_src_reg <= 8'h0;
        acc_ip_reg <= 8'h0;
        acc_l4_reg <= 8'h0;
        typelen_reg <= 16'h0;
        proto_reg <= 8'h0;
      end else if (pos < 14'd6) begin
        acc_dst_reg <= acc_dst_reg ^ rx_data_i;
      end else if (pos < 14'd12) begin
        acc_src_reg <= acc_src_reg ^ rx_data_i;
      end else if (pos < 14'd14) begin
        typelen_reg <= {typelen_reg[7:0], rx_data_i};
      end else if (pos == 14'd23) begin
        proto_reg <= rx_data_i;
      end else if (pos >= 14'd26 && pos < 14'd34 && is_ip) begin
        acc_ip_reg <= acc_ip_reg ^ rx_data_i;
      end else if (pos >= 14'd34 && pos < 14'd38 && is_l4) begin
        acc_l4_reg <= acc_l4_reg ^ rx_data_i;
      end
    end
  end
  // frame length at end of frame, counting fcs
  assign total = pos + 14'h1;
  assign payload = (total > `SPF_HDR_FCS) ? (total - `SPF_HDR_FCS) : 14'h0;
  assign oversize = total > maxlen_reg;
  // small type field is a length; compare it with the payload
  assign len_bad = ctrl_reg.len_check & (typelen_reg <= `SPF_TYPE_MAX) &
                   ({2'h0, payload} != typelen_reg);
  // enabled contributors folded, then reduced over active members
  assign hash_val = (hash_reg.use_src ? acc_src_reg : 8'h0) ^
                    (hash_reg.use_dst ? acc_dst_reg : 8'h0) ^
                    (hash_reg.use_ip ? acc_ip_reg : 8'h0) ^
                    (hash_reg.use_l4 ? acc_l4_reg : 8'h0);
  assign mem_cnt = (hash_reg.members == 4'h0) ? 4'h1 :
                   ((hash_reg.members > 4'h8) ? 4'h8 : hash_reg.members);
  assign hash_mod = hash_val % {4'h0, mem_cnt};
  // verdict at end of frame; last header byte arrives before end
  wire rx_end = rx_take & rx_eof_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      verdict_reg <= '0;
    end else if (rx_end) begin
      verdict_reg.drop_size <= oversize;
      verdict_reg.drop_len <= ~oversize & len_bad;
      verdict_reg.pass <= ~oversize & ~len_bad;
      verdict_reg.member <= hash_mod[2:0];
    end
  end
  // completion pulse one cycle after end of frame
  logic done_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= rx_end;
    end
  end
  assign rx_done_o = done_reg;
  assign rx_pass_o = done_reg & verdict_reg.pass;
  assign rx_drop_o = done_reg & ~verdict_reg.pass;
  assign egress_member_o = verdict_reg.member;
  // statistics: oversize and collision discards only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      size_drops_reg <= 16'h0;
      col_drops_reg <= 16'h0;
    end else begin
      if (done_reg & verdict_reg.drop_size) begin
        size_drops_reg <= size_drops_reg + 16'h1;
      end
      if (abort_reg) begin
        col_drops_reg <= col_drops_reg + 16'h1;
      end
    end
  end
  // checks
  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  chk_fx_no_pause: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_reg.speed == SPF_SPD_100FX) |-> !pause_obey_o && !pause_gen_o && an_adv_pause_o == 2'h0)
    else $error("pause active in fibre mode");
  chk_pfc_excl_pause: assert property (@(posedge clk_i) disable iff (rst_i)
    (pfc_pause_o != 8'h0) |-> !pause_obey_o && !pause_gen_o) else $error("pfc with pause");
  chk_pfc_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    (pfc_pause_o & ~ctrl_reg.pfc_prio) == 8'h0) else $error("pfc outside mask");
  chk_adv_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (an_adv_speed_o & ~ctrl_reg.adv_speed) == 3'h0) else $error("unmasked speed");
  chk_col_discard: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_abort_o |-> $past(tx_collision_i) && $past(col_cnt_reg) == 5'hf &&
    !$past(ctrl_reg.col_restart))
    else $error("abort not at sixteenth collision");
  chk_col_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_backoff_restart_o |-> $past(ctrl_reg.col_restart) && $past(col_cnt_reg) == 5'hf)
    else $error("restart not at sixteenth collision");
  chk_len_uncounted: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_reg && verdict_reg.drop_len) |=> $stable(size_drops_reg))
    else $error("length drop counted");
  chk_maxlen_range: assert property (@(posedge clk_i) disable iff (rst_i)
    maxlen_reg >= `SPF_MAXLEN_MIN && maxlen_reg <= `SPF_MAXLEN_MAX)
    else $error("limit out of range");
  chk_member_range: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_done_o |-> {1'b0, egress_member_o} < mem_cnt) else $error("member out of range");
  chk_done_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_end |=> rx_done_o && (rx_pass_o ^ rx_drop_o)) else $error("no verdict after end");
endmodule

// >>> bench/spf_link_partner.sv
// link partner model that answers auto-negotiation requests
`timescale 1ns/1ps
module spf_link_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the bench
  input wire logic req_i,
  input wire logic slow_i,
  input wire logic [1:0] cap_i,
  // negotiation outcome
  output logic done_o,
  output logic pause_o,
  output logic asym_o
);
  int cnt;  // cycles left before answering
  logic [1:0] last_cap = 2'h0;  // abilities last reported
  // answer after 1 or 25 cycles; outside the done pulse the ability lines carry junk
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    {pause_o, asym_o} <= ~last_cap;
    if (rst_i) begin
      cnt <= 0;
    end else if (cnt == 1) begin
      done_o <= 1'b1;
      {pause_o, asym_o} <= cap_i;
      last_cap <= cap_i;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (req_i) begin
      cnt <= slow_i ? 25 : 1;
    end
  end
endmodule

// >>> bench/test_spf_top.sv
// self-checking bench for the port policy and trunk hash block
`timescale 1ns/1ps
`include "spf_map.svh"
module test_spf_top;
  import spf_pkg::*;
  // clock, reset and bus drive
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  // flow control, collision and receive drive
  logic an_done_i, an_partner_pause_i, an_partner_asym_i;
  logic [7:0] pfc_congest_i = 8'h00;
  logic tx_start_i = 1'b0;
  logic tx_collision_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic rx_sof_i = 1'b0;
  logic rx_eof_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  // design outputs
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pause_obey_o, pause_gen_o, tx_abort_o, tx_backoff_restart_o;
  logic rx_done_o, rx_pass_o, rx_drop_o;
  logic [2:0] an_adv_speed_o, egress_member_o;
  logic [1:0] an_adv_pause_o;
  logic [7:0] pfc_pause_o;
  // partner request
  logic neg_req = 1'b0;
  logic neg_slow = 1'b0;
  logic [1:0] neg_cap = 2'h0;
  // bookkeeping
  int fails = 0;
  int checks = 0;
  logic [7:0] fr [0:2047];  // frame under construction
  spf_ctrl_type cw;  // control word to write
  logic [31:0] d, s0;  // read data
  logic [3:0] en;  // hash contributors
  logic [3:0] lanes = 4'hf;  // byte lanes for the next bus cycle
  always #25 clk_i = ~clk_i;
  spf_top spf_top_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .an_done_i, .an_partner_pause_i, .an_partner_asym_i,
    .an_adv_speed_o, .an_adv_pause_o, .pfc_congest_i, .pfc_pause_o, .pause_obey_o,
    .pause_gen_o, .tx_start_i, .tx_collision_i, .tx_abort_o, .tx_backoff_restart_o,
    .rx_valid_i, .rx_sof_i, .rx_eof_i, .rx_data_i, .rx_done_o, .rx_pass_o, .rx_drop_o,
    .egress_member_o
  );
  spf_link_partner spf_link_partner_i (
    .clk_i, .rst_i, .req_i(neg_req), .slow_i(neg_slow), .cap_i(neg_cap),
    .done_o(an_done_i), .pause_o(an_partner_pause_i), .asym_o(an_partner_asym_i)
  );
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= lanes;
    wb_dat_i <= dat;
    // wait as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
      #1;
    end while (wb_ack_o !== 1'b1);
    @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // let the write land before the caller looks at outputs
    #1;
  endtask
  // ask the partner to negotiate, then let the outcome settle
  task automatic neg(input logic [1:0] cap, input logic slow);
    @(posedge clk_i);
    neg_req <= 1'b1;
    neg_cap <= cap;
    neg_slow <= slow;
    @(posedge clk_i);
    neg_req <= 1'b0;
    repeat (30) @(posedge clk_i);
    #1;
  endtask
  // random frame body with a given type/length field
  function automatic void fill(input int len, input logic [15:0] tl);
    for (int i = 0; i < len; i++) fr[i] = 8'($urandom);
    fr[12] = tl[15:8];
    fr[13] = tl[7:0];
  endfunction
  // stream the frame with random gaps, wait for the verdict pulse
  task automatic send(input int len);
    int n;
    logic gap;
    n = 0;
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      gap = ($urandom_range(7) == 0);
      rx_valid_i <= !gap;
      rx_sof_i <= (i == 0);
      rx_eof_i <= (i == len - 1);
      rx_data_i <= fr[i];
      // a gap holds the byte idle for one cycle, then offers it
      if (gap) begin
        @(posedge clk_i);
        rx_valid_i <= 1'b1;
      end
    end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    rx_eof_i <= 1'b0;
    #1;
    while (rx_done_o !== 1'b1 && n < 5) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("rx_done", rx_done_o, 32'h1);
  endtask
  // send one frame and compare the verdict
  task automatic frm(input int len, input logic [15:0] tl, input logic ok);
    fill(len, tl);
    send(len);
    check("rx_pass", rx_pass_o, {31'h0, ok});
    check("rx_drop", rx_drop_o, {31'h0, !ok});
  endtask
  // collisions after an optional frame start; sticky pulse capture
  task automatic coll(input logic st, input int n, input logic ab, input logic rs);
    logic sa, sr;
    sa = 1'b0;
    sr = 1'b0;
    @(posedge clk_i);
    tx_start_i <= st;
    @(posedge clk_i);
    tx_start_i <= 1'b0;
    repeat (n) @(posedge clk_i) tx_collision_i <= 1'b1;
    @(posedge clk_i);
    tx_collision_i <= 1'b0;
    repeat (4) begin
      #1;
      sa |= tx_abort_o;
      sr |= tx_backoff_restart_o;
      @(posedge clk_i);
    end
    check("tx_abort", sa, {31'h0, ab});
    check("tx_restart", sr, {31'h0, rs});
  endtask
  // expected trunk member: xor fold of enabled fields, modulo members
  function automatic logic [31:0] hexp(input logic [3:0] e, input int m);
    logic [7:0] a;
    a = 8'h00;
    for (int i = 0; i < 38; i++) begin
      if ((i < 6 && e[1]) || (i >= 6 && i < 12 && e[0]) ||
          (i >= 26 && i < 34 && e[2]) || (i >= 34 && e[3])) a = a ^ fr[i];
    end
    return 32'(a % m);
  endfunction
  // watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    close_out();
  end
  // main sequence
  initial begin
    void'($urandom(32'he567));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `SPF_ADR_CTRL, 32'h0, d);
    check("ctrl_rst", d, `SPF_CTRL_RST);
    wb(1'b0, `SPF_ADR_HASH, 32'h0, d);
    check("hash_rst", d, `SPF_HASH_RST);
    wb(1'b0, 8'h14, 32'h0, d);
    check("unmapped", d, 32'h0);
    check("adv_speed", an_adv_speed_o, 32'h7);
    // a single byte lane write touches only the priority mask
    lanes = 4'h2;
    wb(1'b1, `SPF_ADR_CTRL, 32'hffffffff, d);
    lanes = 4'hf;
    wb(1'b0, `SPF_ADR_CTRL, 32'h0, d);
    check("sel_lanes", d, `SPF_CTRL_RST | 32'h0000ff00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cw = `SPF_CTRL_RST;
      cw.adv_speed = 3'($urandom);
      wb(1'b1, `SPF_ADR_CTRL, cw, d);
      check("adv_speed", an_adv_speed_o, cw.adv_speed);
      cw.pause_rx = 1'($urandom);
      cw.pause_tx = 1'($urandom);
      wb(1'b1, `SPF_ADR_CTRL, cw, d);
      check("adv_pause", an_adv_pause_o, {cw.pause_tx, cw.pause_rx});
      neg(2'(i), i[0]);
      check("obey", pause_obey_o, cw.pause_rx & i[1]);
      check("gen", pause_gen_o, cw.pause_tx & (i[1] | i[0]));
    end
    $display("test negotiation done");
    for (int i = 0; i < 4; i++) begin
      cw = `SPF_CTRL_RST;
      cw.speed = i[0] ? SPF_SPD_FIXED : SPF_SPD_FIXED2;
      cw.pause_rx = i[1];
      cw.pause_tx = !i[0];
      wb(1'b1, `SPF_ADR_CTRL, cw, d);
      neg(2'h0, 1'b0);
      check("obey_fix", pause_obey_o, cw.pause_rx);
      check("gen_fix", pause_gen_o, cw.pause_tx);
    end
    cw = `SPF_CTRL_RST;
    cw.speed = SPF_SPD_100FX;
    wb(1'b1, `SPF_ADR_CTRL, cw, d);
    neg(2'h3, 1'b0);
    check("obey_fx", pause_obey_o, 32'h0);
    check("gen_fx", pause_gen_o, 32'h0);
    wb(1'b0, `SPF_ADR_STATUS, 32'h0, d);
    check("status_fx", d[1:0], 32'h0);
    $display("test fixed speed done");
    cw = `SPF_CTRL_RST;
    cw.pfc_en = 1'b1;
    cw.pfc_prio = 8'($urandom);
    wb(1'b1, `SPF_ADR_CTRL, cw, d);
    neg(2'h3, 1'b0);
    repeat (4) begin
      @(posedge clk_i) pfc_congest_i <= 8'($urandom);
      @(posedge clk_i);
      #1;
      check("pfc_pause", pfc_pause_o, pfc_congest_i & cw.pfc_prio);
      check("obey_pfc", pause_obey_o | pause_gen_o, 32'h0);
    end
    cw.pfc_en = 1'b0;
    wb(1'b1, `SPF_ADR_CTRL, cw, d);
    check("pfc_off", pfc_pause_o, 32'h0);
    $display("test pfc done");
    coll(1'b1, 15, 1'b0, 1'b0);
    coll(1'b0, 1, 1'b1, 1'b0);
    cw.col_restart = 1'b1;
    wb(1'b1, `SPF_ADR_CTRL, cw, d);
    coll(1'b1, 16, 1'b0, 1'b1);
    $display("test collisions done");
    wb(1'b0, `SPF_ADR_STATS, 32'h0, s0);
    frm(64, 16'h002e, 1'b1);
    frm(64, 16'h002d, 1'b0);
    frm(60, 16'h05ff, 1'b0);
    frm(60, 16'h0600, 1'b1);
    frm(1519, 16'h0800, 1'b0);
    frm(1518, 16'h0800, 1'b1);
    wb(1'b0, `SPF_ADR_STATS, 32'h0, d);
    check("drops", d[15:0], 16'(s0[15:0] + 16'h0001));
    wb(1'b1, `SPF_ADR_MAXLEN, 32'h0000ffff, d);
    wb(1'b0, `SPF_ADR_MAXLEN, 32'h0, d);
    check("maxlen_hi", d, 32'h00002800);
    frm(1519, 16'h0800, 1'b1);
    wb(1'b1, `SPF_ADR_MAXLEN, 32'h00000010, d);
    wb(1'b0, `SPF_ADR_MAXLEN, 32'h0, d);
    check("maxlen_lo", d, 32'h000005ee);
    cw.len_check = 1'b0;
    wb(1'b1, `SPF_ADR_CTRL, cw, d);
    frm(64, 16'h002d, 1'b1);
    $display("test length done");
    for (int m = 1; m <= 8; m++) begin
      en = (m == 1) ? 4'hd : 4'($urandom);
      wb(1'b1, `SPF_ADR_HASH, {24'h0, 4'(m), en}, d);
      fill(64, 16'h0800);
      fr[23] = m[0] ? 8'h06 : 8'h11;
      repeat (2) begin
        send(64);
        check("member", egress_member_o, hexp(en, m));
      end
    end
    $display("test trunk hash done");
    close_out();
  end
endmodule
